/* File: pkg/poe_status_pkg.sv */
// Purpose: constants and types for the per-port status and converter result registers
// Assumes: four ports, 8-bit register data, 4-bit register select
// Notes:   Operation list below
// Operation
// - set function-complete on finish; clear on new function write for that port.
// - detected class reported in bits 5..3, classes 0..4 as 000..100.
// - fault code in bits 2..0: none, undervolt_overvolt_fault, thermal, overload, disconnect.
// - fault codes 101, 110, 111 are never produced.
// - converter-active bit 3 of second status high while converting.
// - port state in bits 2..0: disabled, searching, power, fault, test, other.
// - port state codes 110 and 111 are never reported.
// - resistance-complete flag cleared when either discovery phase starts.
// - resistance-complete flag set when the discovery conversion finishes.
// - 15-bit discovery current: low byte at 0110, upper seven bits at 0111.
// - voltage result low byte at select 1000, one per port.
// - discovery-failure bit 7 set on failed discovery, cleared on passed discovery.
// - voltage-complete flag cleared when conversion begins, set when it ends.
// - converter start bit set by host, cleared by device once conversion began.
package poe_status_pkg;
  localparam int unsigned PORT_COUNT     = 4;
  localparam int unsigned ADC_BITS       = 15;
  localparam logic [3:0]  SEL_STATUS_ONE = 4'h4;
  localparam logic [3:0]  SEL_STATUS_TWO = 4'h5;
  localparam logic [3:0]  SEL_DISC_LOW   = 4'h6;
  localparam logic [3:0]  SEL_DISC_HIGH  = 4'h7;
  localparam logic [3:0]  SEL_VOLT_LOW   = 4'h8;
  localparam logic [3:0]  SEL_VOLT_HIGH  = 4'h9;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int unsigned FLAG_BIT       = 7;
  localparam int unsigned DONE_BIT       = 6;
  localparam int unsigned WDOG_BIT       = 4;
  localparam int unsigned ADC_ACT_BIT    = 3;

  typedef enum logic [2:0] {
    fault_none_type_v                 = 3'h0,
    undervolt_overvolt_fault          = 3'h1,
    thermal_shutdown_fault_code       = 3'h2,
    fault_overload_v                  = 3'h3,
    fault_disconnect_v                = 3'h4
  } fault_type;

  typedef enum logic [2:0] {
    st_disabled = 3'h0,
    st_search   = 3'h1,
    st_power    = 3'h3,
    st_fault    = 3'h2,
    st_test     = 3'h6,
    st_other    = 3'h7
  } pstate_type;

  // reported port-state codes and the largest reported class code
  localparam logic [2:0] CODE_DISABLED = 3'h0;
  localparam logic [2:0] CODE_SEARCH   = 3'h1;
  localparam logic [2:0] CODE_POWER    = 3'h2;
  localparam logic [2:0] CODE_FAULT    = 3'h3;
  localparam logic [2:0] CODE_TEST     = 3'h4;
  localparam logic [2:0] CODE_OTHER    = 3'h5;
  localparam logic [2:0] CLASS_MAX     = 3'h4;

  // per-port events from the analog/function core
  typedef struct packed {
    logic        func_write;   // host wrote a new function code
    logic        func_done;    // commanded function finished
    logic        disc_start;   // discovery 1 or 2 started
    logic        disc_fail;    // discovery verdict fail
    logic        disc_pass;    // discovery verdict pass
    logic [2:0]  pd_class;
    fault_type   fault;
    logic        fault_valid;
    pstate_type  pstate;
    logic        wdog_active;
    logic        adc_start_wr; // host wrote one to converter start
    logic        adc_is_volt;  // pending conversion is a voltage sample
    logic        adc_is_disc;  // pending conversion belongs to discovery
  } port_event_type;

  // converter core handshake
  typedef struct packed {
    logic        begun;
    logic        done;
    logic [14:0] result;
  } adc_type;
endpackage

/* File: hdl/poe_adc_track.sv */
// Purpose: one port's converter start bit, activity flag and result capture
// Assumes: converter reports begun then done, one pulse each
// Notes:   start bit self-clears once conversion has begun
`timescale 1ns/10ps
`default_nettype none
module poe_adc_track
  import poe_status_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // control
  input  wire logic        start_wr_i,
  input  wire logic        is_volt_i,
  input  wire logic        is_disc_i,
  input  wire adc_type     adc_i,
  // state
  output logic             start_q_o,
  output logic             active_o,
  output logic             disc_conv_o,
  output logic             volt_done_o,
  output logic [14:0]      volt_res_o
);
  logic        start_q, start_d, act_q, act_d, volt_q, volt_d, disc_q, disc_d;
  logic        vdone_q, vdone_d;
  logic [14:0] vres_q, vres_d;

  // start bit, activity and voltage capture
  always_comb begin
    start_d = start_q;
    act_d   = act_q;
    volt_d  = volt_q;
    disc_d  = disc_q;
    vdone_d = vdone_q;
    vres_d  = vres_q;
    if (start_wr_i) begin
      start_d = 1'b1;
      volt_d  = is_volt_i;
      disc_d  = is_disc_i;
    end
    if (adc_i.begun) begin
      start_d = 1'b0;
      act_d   = 1'b1;
      if (volt_q) vdone_d = 1'b0;
    end
    if (adc_i.done && act_q) begin
      act_d = 1'b0;
      if (volt_q) begin
        vdone_d = 1'b1;
        vres_d  = adc_i.result;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_q <= 1'b0;
      act_q   <= 1'b0;
      volt_q  <= 1'b0;
      disc_q  <= 1'b0;
      vdone_q <= 1'b0;
      vres_q  <= '0;
    end else begin
      start_q <= start_d;
      act_q   <= act_d;
      volt_q  <= volt_d;
      disc_q  <= disc_d;
      vdone_q <= vdone_d;
      vres_q  <= vres_d;
    end
  end

  assign start_q_o   = start_q;
  assign active_o    = act_q;
  assign disc_conv_o = disc_q;
  assign volt_done_o = vdone_q;
  assign volt_res_o  = vres_q;

  chk_start_clears: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    adc_i.begun && !start_wr_i |=> !start_q) else $error("start bit not cleared");
  chk_active_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    adc_i.begun && !adc_i.done |=> act_q) else $error("active not set");
endmodule
`default_nettype wire

/* File: hdl/poe_state_encode.sv */
// Purpose: map internal port state and fault onto reported codes
// Assumes: unknown inputs fall back to safe codes
// Notes:   codes 110 and 111 can never leave this module
`timescale 1ns/10ps
`default_nettype none
module poe_state_encode
  import poe_status_pkg::*;
(
  // inputs
  input  wire pstate_type  pstate_i,
  input  wire logic [2:0]  fault_i,
  input  wire logic [2:0]  class_i,
  // encoded
  output logic [2:0]       state_code_o,
  output logic [2:0]       fault_code_o,
  output logic [2:0]       class_code_o
);
  // encode; out-of-range class is clamped, out-of-range fault reads none, never passed through
  always_comb begin
    case (pstate_i)
      st_disabled: state_code_o = CODE_DISABLED;
      st_search:   state_code_o = CODE_SEARCH;
      st_power:    state_code_o = CODE_POWER;
      st_fault:    state_code_o = CODE_FAULT;
      st_test:     state_code_o = CODE_TEST;
      st_other:    state_code_o = CODE_OTHER;
      default:     state_code_o = CODE_OTHER;
    endcase
    fault_code_o = (fault_i > 3'h4) ? 3'h0 : fault_i;
    class_code_o = (class_i > CLASS_MAX) ? CLASS_MAX : class_i;
  end
endmodule
`default_nettype wire

/* File: hdl/poe_port_status_adc_regs.sv */
// Purpose: per-port read-only status and converter result registers
// Assumes: host selects port and register; read data registered
// Notes:   writes to these selects are ignored
`timescale 1ns/10ps
`default_nettype none
module poe_port_status_adc_regs
  import poe_status_pkg::*;
#(
  parameter int unsigned PORTS = PORT_COUNT
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  // register access
  input  wire logic [1:0]       port_sel_i,
  input  wire logic [3:0]       reg_sel_i,
  input  wire logic             rd_en_i,
  // core events
  input  wire port_event_type   evt_i [PORTS],
  input  wire adc_type          adc_i [PORTS],
  // read back
  output logic [7:0]            rd_data_o,
  output logic                  rd_valid_o,
  output logic [PORTS-1:0]      adc_start_o
);
  // port select is two bits wide, so only four ports can be addressed
  if (PORTS != 4) begin : gen_bad_ports
    $error("four ports only");
  end

  logic [7:0]  st1_q [PORTS];
  logic [7:0]  st1_d [PORTS];
  logic [7:0]  st2_q [PORTS];
  logic [7:0]  st2_d [PORTS];
  logic [14:0] disc_q [PORTS];
  logic [14:0] disc_d [PORTS];
  logic        rdone_q [PORTS];
  logic        rdone_d [PORTS];
  logic        vdone [PORTS];
  logic [14:0] vres [PORTS];
  logic        act [PORTS];
  logic        dconv [PORTS];
  logic [PORTS-1:0] start_w;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : gen_port
      logic [2:0] scode, fcode, ccode;

      poe_adc_track u_trk (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .start_wr_i  (evt_i[g].adc_start_wr),
        .is_volt_i   (evt_i[g].adc_is_volt),
        .is_disc_i   (evt_i[g].adc_is_disc),
        .adc_i       (adc_i[g]),
        .start_q_o   (start_w[g]),
        .active_o    (act[g]),
        .disc_conv_o (dconv[g]),
        .volt_done_o (vdone[g]),
        .volt_res_o  (vres[g])
      );

      poe_state_encode u_enc (
        .pstate_i     (evt_i[g].pstate),
        .fault_i      (evt_i[g].fault_valid ? 3'(evt_i[g].fault) : 3'h0),
        .class_i      (evt_i[g].pd_class),
        .state_code_o (scode),
        .fault_code_o (fcode),
        .class_code_o (ccode)
      );

      // status one: fail, done, class, fault
      always_comb begin
        st1_d[g] = st1_q[g];
        if (evt_i[g].disc_pass) st1_d[g][FLAG_BIT] = 1'b0;
        if (evt_i[g].disc_fail) st1_d[g][FLAG_BIT] = 1'b1;
        if (evt_i[g].func_write) st1_d[g][DONE_BIT] = 1'b0;
        if (evt_i[g].func_done) st1_d[g][DONE_BIT] = 1'b1; // set wins
        st1_d[g][5:3] = ccode;
        st1_d[g][2:0] = fcode;
      end

      // status two: watchdog, converter active, port state
      always_comb begin
        st2_d[g] = REG_RESET;
        st2_d[g][WDOG_BIT]    = evt_i[g].wdog_active;
        st2_d[g][ADC_ACT_BIT] = act[g];
        st2_d[g][2:0]         = scode;
      end

      // discovery result and resistance-complete flag
      always_comb begin
        disc_d[g]  = disc_q[g];
        rdone_d[g] = rdone_q[g];
        if (evt_i[g].disc_start) rdone_d[g] = 1'b0;
        if (adc_i[g].done && act[g] && dconv[g]) begin
          rdone_d[g] = 1'b1;
          disc_d[g]  = adc_i[g].result;
        end
      end

      // registers reset to zero, only hardware updates them
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          st1_q[g]   <= REG_RESET;
          st2_q[g]   <= REG_RESET;
          disc_q[g]  <= '0;
          rdone_q[g] <= 1'b0;
        end else begin
          st1_q[g]   <= st1_d[g];
          st2_q[g]   <= st2_d[g];
          disc_q[g]  <= disc_d[g];
          rdone_q[g] <= rdone_d[g];
        end
      end

      chk_fault_legal: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        st1_q[g][2:0] <= 3'h4) else $error("reserved fault code");
      chk_state_legal: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        st2_q[g][2:0] <= 3'h5) else $error("undefined port state");
      chk_done_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        evt_i[g].func_write && !evt_i[g].func_done |=> !st1_q[g][DONE_BIT])
        else $error("done not cleared");
      chk_rdone_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        evt_i[g].disc_start && !(adc_i[g].done && act[g] && dconv[g]) |=> !rdone_q[g])
        else $error("resistance flag not cleared");
      chk_fail_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        evt_i[g].disc_fail |=> st1_q[g][FLAG_BIT]) else $error("fail flag missing");
      chk_class_track: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        evt_i[g].pd_class <= CLASS_MAX |=> st1_q[g][5:3] == $past(evt_i[g].pd_class))
        else $error("class mismatch");
      cov_disc_done: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        evt_i[g].disc_start ##[1:50] rdone_q[g]);
      cov_volt_done: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(vdone[g]));
      cov_func_done: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(st1_q[g][DONE_BIT]));
    end
  endgenerate

  // read mux; unmapped selects read zero
  logic [7:0] rd_d;
  logic [7:0] rd_q;
  logic       rv_q;
  logic [PORTS-1:0] start_q;
  always_comb begin
    rd_d = rd_q;
    if (rd_en_i) begin
      case (reg_sel_i)
        SEL_STATUS_ONE: rd_d = st1_q[port_sel_i];
        SEL_STATUS_TWO: rd_d = st2_q[port_sel_i];
        SEL_DISC_LOW:   rd_d = disc_q[port_sel_i][7:0];
        SEL_DISC_HIGH:  rd_d = {rdone_q[port_sel_i], disc_q[port_sel_i][14:8]};
        SEL_VOLT_LOW:   rd_d = vres[port_sel_i][7:0];
        SEL_VOLT_HIGH:  rd_d = {vdone[port_sel_i], vres[port_sel_i][14:8]};
        default:        rd_d = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_q    <= REG_RESET;
      rv_q    <= 1'b0;
      start_q <= '0;
    end else begin
      rd_q    <= rd_d;
      rv_q    <= rd_en_i;
      start_q <= start_w;
    end
  end

  assign rd_data_o   = rd_q;
  assign rd_valid_o  = rv_q;
  assign adc_start_o = start_q;

  chk_read_lat: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    rd_en_i && reg_sel_i == SEL_STATUS_TWO |=> rd_data_o == $past(st2_q[port_sel_i]))
    else $error("read data wrong");
  chk_read_valid: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    rd_en_i |=> rd_valid_o ##1 (rd_valid_o == $past(rd_en_i)))
    else $error("valid timing wrong");
  cov_read_high: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    rd_en_i && reg_sel_i == SEL_DISC_HIGH);
endmodule
`default_nettype wire

/* File: dv/poe_adc_model.sv */
// Purpose: converter core stand-in for all four ports
// Assumes: start bits come from the block under test
// Notes:   result lines carry inverted junk outside the done pulse
`timescale 1ns/10ps
`default_nettype none
module poe_adc_model
  import poe_status_pkg::*;
#(
  parameter int unsigned BEGIN_DLY = 3,
  parameter int unsigned CONV_DLY  = 12
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // converter side
  input  wire logic [3:0]  start_i,
  input  wire logic [14:0] res_i [4],
  output var  adc_type     adc_o [4]
);
  logic [1:0] phase_q [4];
  int         cnt_q   [4];

  // begun only after a start is seen, done a fixed time later
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    for (int p = 0; p < 4; p++) begin
      if (reset_i) begin
        phase_q[p] <= 2'h0;
        cnt_q[p]   <= 0;
        adc_o[p]   <= '0;
      end else begin
        adc_o[p].begun  <= 1'b0;
        adc_o[p].done   <= 1'b0;
        adc_o[p].result <= ~adc_o[p].result; // never a stale value to latch
        cnt_q[p]        <= cnt_q[p] + 1;
        case (phase_q[p])
          2'h0: if (start_i[p]) begin
            phase_q[p] <= 2'h1;
            cnt_q[p]   <= 0;
          end
          2'h1: if (cnt_q[p] == BEGIN_DLY) begin
            adc_o[p].begun <= 1'b1;
            phase_q[p]     <= 2'h2;
            cnt_q[p]       <= 0;
          end
          default: if (cnt_q[p] == CONV_DLY) begin
            adc_o[p].done   <= 1'b1;
            adc_o[p].result <= res_i[p];
            phase_q[p]      <= 2'h0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_poe_port_status_adc_regs.sv */
// Purpose: self-checking bench for the port status and result registers
// Assumes: one read per two cycles, inputs driven at the falling edge
// Notes:   short converter delays keep polling loops small
`timescale 1ns/10ps
`default_nettype none
module tb_poe_port_status_adc_regs;
  import poe_status_pkg::*;
  logic           sys_clk_i;
  logic           reset_i;
  logic           rd_en_i;
  logic [1:0]     port_sel_i;
  logic [3:0]     reg_sel_i;
  port_event_type evt_i [4];
  adc_type        adc_w [4];
  logic [14:0]    res [4];
  logic [7:0]     rd_data_o;
  logic           rd_valid_o;
  logic [3:0]     adc_start_o;
  int             mismatches;
  int             comparisons;

  poe_port_status_adc_regs #(.PORTS(4)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .port_sel_i(port_sel_i),
    .reg_sel_i(reg_sel_i), .rd_en_i(rd_en_i), .evt_i(evt_i), .adc_i(adc_w),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .adc_start_o(adc_start_o));

  poe_adc_model #(.BEGIN_DLY(3), .CONV_DLY(12)) far_end (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .start_i(adc_start_o),
    .res_i(res), .adc_o(adc_w));

  // 125 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one read strobe, answer taken one cycle later
  task automatic rd(input logic [1:0] p, input logic [3:0] s, output logic [7:0] d);
    @(negedge sys_clk_i);
    port_sel_i = p;
    reg_sel_i  = s;
    rd_en_i    = 1'b1;
    @(negedge sys_clk_i);
    rd_en_i = 1'b0;
    check("read valid", {7'h0, rd_valid_o}, 8'h01);
    d = rd_data_o;
  endtask

  task automatic rd_chk(input logic [1:0] p, input logic [3:0] s, input logic [7:0] e);
    logic [7:0] d;
    rd(p, s, d);
    check("register", d, e);
  endtask

  // bounded wait for masked value
  task automatic poll(input logic [1:0] p, input logic [3:0] s, input logic [7:0] m);
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(p, s, d);
      if ((d & m) === m) return;
    end
    mismatches++;
    $display("[FAIL] poll sel %h expected %h seen %h", s, m, d & m);
    tally_and_finish();
  endtask

  // drop every pulse field one cycle after it was raised
  task automatic step;
    @(negedge sys_clk_i);
    for (int p = 0; p < 4; p++) begin
      evt_i[p].func_write   = 1'b0;
      evt_i[p].func_done    = 1'b0;
      evt_i[p].disc_start   = 1'b0;
      evt_i[p].disc_fail    = 1'b0;
      evt_i[p].disc_pass    = 1'b0;
      evt_i[p].adc_start_wr = 1'b0;
    end
  endtask

  task automatic t_reset;
    for (int p = 0; p < 4; p++)
      for (int s = 4; s < 10; s++)
        rd_chk(2'(p), 4'(s), REG_RESET);
    rd_chk(2'h0, 4'hf, 8'h00);
  endtask

  task automatic t_status_one;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk_i);
      evt_i[2].pd_class    = 3'(i);
      evt_i[2].fault       = fault_type'(3'(i));
      evt_i[2].fault_valid = 1'b1;
      rd(2'h2, SEL_STATUS_ONE, d);
      check("class", {5'h0, d[5:3]}, (i > 4) ? 8'h04 : 8'(i));
      check("fault", {5'h0, d[2:0]}, (i > 4) ? 8'h00 : 8'(i));
    end
    rd_chk(2'h0, SEL_STATUS_ONE, 8'h00);
    evt_i[2].pd_class    = 3'h1;
    evt_i[2].fault_valid = 1'b0;
    evt_i[2].func_done   = 1'b1;
    step();
    rd_chk(2'h2, SEL_STATUS_ONE, 8'h48);
    evt_i[2].func_write = 1'b1;
    step();
    rd_chk(2'h2, SEL_STATUS_ONE, 8'h08);
    evt_i[2].disc_fail = 1'b1;
    step();
    rd_chk(2'h2, SEL_STATUS_ONE, 8'h88);
    evt_i[2].disc_pass = 1'b1;
    step();
    rd_chk(2'h2, SEL_STATUS_ONE, 8'h08);
  endtask

  task automatic t_status_two;
    pstate_type ps [8];
    ps = '{st_disabled, st_search, st_power, st_fault, st_test, st_other,
           pstate_type'(3'h4), pstate_type'(3'h5)};
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk_i);
      evt_i[0].pstate      = ps[i];
      evt_i[0].wdog_active = i[0];
      rd_chk(2'h0, SEL_STATUS_TWO, {3'h0, i[0], 1'b0, (i > 5) ? 3'h5 : 3'(i)});
    end
  endtask

  // one conversion, voltage or discovery, with flag and byte checks
  task automatic t_conv(input logic [1:0] p, input logic disc, input logic [14:0] r);
    logic [7:0] d;
    logic [3:0] sl;
    sl     = disc ? SEL_DISC_LOW : SEL_VOLT_LOW;
    res[p] = r;
    evt_i[p].disc_start = disc;
    step();
    evt_i[p].adc_is_volt  = ~disc;
    evt_i[p].adc_is_disc  = disc;
    evt_i[p].adc_start_wr = 1'b1;
    step();
    poll(p, SEL_STATUS_TWO, 8'h08);
    check("start bit", {7'h0, adc_start_o[p]}, 8'h00);
    rd(p, sl + 4'h1, d);
    check("done flag", {7'h0, d[7]}, 8'h00);
    poll(p, sl + 4'h1, 8'h80);
    rd_chk(p, SEL_STATUS_TWO, 8'h00);
    rd_chk(p, sl, r[7:0]);
    rd_chk(p, sl + 4'h1, {1'b1, r[14:8]});
    rd_chk(p ^ 2'h1, sl, 8'h00);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    mismatches  = 0;
    comparisons = 0;
    reset_i     = 1'b1;
    rd_en_i     = 1'b0;
    port_sel_i  = 2'h0;
    reg_sel_i   = 4'h0;
    for (int p = 0; p < 4; p++) begin
      evt_i[p] = '0;
      res[p]   = '0;
    end
    repeat (2) @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_reset();
    t_status_one();
    t_status_two();
    t_conv(2'h1, 1'b0, 15'h5a3c);
    t_conv(2'h1, 1'b0, 15'h0123);
    t_conv(2'h3, 1'b1, 15'h2b81);
    t_conv(2'h3, 1'b1, 15'h7e00);
    // mid-run reset must wipe flags and results that the runs above left set
    for (int p = 0; p < 4; p++) evt_i[p] = '0;
    reset_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
